// ==== logic/fwd_cfg.svh ====
`ifndef FWD_CFG_SVH
`define FWD_CFG_SVH

// ==========================================================================
// Register offsets on the management port.
`define OFS_TAG_HIGH_MAP 8'h81
`define OFS_QUEUE_SPLIT 8'h82
`define OFS_UNK_UCAST 8'h83
`define OFS_DRIVE_UNK_MCAST 8'h84

// ==========================================================================
// Field positions.
`define TAG4_MSB 1
`define TAG4_LSB 0
`define SPLIT_MSB 7
`define SPLIT_LSB 6
`define FWD_EN_BIT 5
`define FWD_MAP_MSB 4
`define FWD_MAP_LSB 0
`define DRIVE_MSB 7
`define DRIVE_LSB 6

// ==========================================================================
// Reset values and fixed read-only contents.
`define TAG4_RESET 2'h2
`define SPLIT_RESET 2'h2
`define DRIVE_RESET 2'h1
`define FWD_EN_RESET 1'h0
`define FWD_MAP_RESET 5'h00
`define SPLIT_RSVD_VALUE 6'h04

// ==========================================================================
// Tag value, split codes and egress port masks.
`define PCP_FOUR 3'h4
`define SPLIT_AT_THREE 2'h0
`define SPLIT_AT_TWO 2'h2
`define SPLIT_AT_ONE 2'h3
`define MAP_PORT1 4'h1
`define MAP_PORT2 4'h2
`define MAP_BOTH 4'h3
`define MAP_ALL 4'hF
`define PORTS_NONE 4'h0
`define PORTS_P1 4'h1
`define PORTS_P2 4'h2
`define PORTS_BOTH 4'h3
`define PORTS_ALL 4'hF

`endif

// ==== logic/fwd_pkg.sv ====
`include "fwd_cfg.svh"

package fwd_pkg;

    // ======================================================================
    // Frame classification request from the lookup engine.
    typedef struct packed {
        logic valid;
        logic [2:0] pcp;
        logic use_ext;
        logic [1:0] ext_prio;
        logic unk_ucast;
        logic unk_mcast;
        logic ip_mcast;
    } frame_req_s;

    // Priority and queue answer.
    typedef struct packed {
        logic valid;
        logic [1:0] prio;
        logic high_queue;
    } prio_res_s;

    // Special forwarding answer for an unknown destination.
    typedef struct packed {
        logic apply;
        logic [3:0] ports;
    } fwd_s;

    // Fold a 2-bit priority onto the low or high queue.
    function automatic logic fold_high(logic [1:0] split, logic [1:0] prio);
        logic hi;
        hi = 1'b0;
        case (split)
            `SPLIT_AT_THREE: hi = (prio == 2'h3);
            `SPLIT_AT_ONE: hi = (prio != 2'h0);
            // split 10.
            // The unsupported code behaves like the reset split.
            default: hi = (prio >= 2'h2);
        endcase
        return hi;
    endfunction : fold_high

    // Decode a port map; bit 0 is ignored, unlisted codes send nowhere.
    function automatic logic [3:0] decode_ports(logic [4:0] map);
        logic [3:0] p;
        p = `PORTS_NONE;
        case (map[4:1])
            `MAP_PORT1: p = `PORTS_P1;
            `MAP_PORT2: p = `PORTS_P2;
            `MAP_BOTH: p = `PORTS_BOTH;
            `MAP_ALL: p = `PORTS_ALL;
            default: p = `PORTS_NONE;
        endcase
        return p;
    endfunction : decode_ports

endpackage : fwd_pkg

// ==== logic/unknown_port_decode.sv ====
`timescale 1ns/100ps
`include "fwd_cfg.svh"

module unknown_port_decode (
    input wire logic mclk, // Core clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic hit, // Frame of this class is presented.
    input wire logic enable, // Special forwarding enabled.
    input wire logic [4:0] port_map, // Programmed port map.
    output fwd_pkg::fwd_s fwd // Registered forwarding answer.
);

    // ======================================================================
    // Decode stage.
    // A disabled map yields no special handling; normal flooding applies.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fwd <= '0;
        end else begin
            fwd.apply <= hit && enable;
            fwd.ports <= (hit && enable) ?
                fwd_pkg::decode_ports(port_map) : `PORTS_NONE;
        end
    end

    // 1111x reaches all ports.
    property p_map_all;
        @(posedge mclk) disable iff (!resetn)
        hit && enable && port_map[4:1] == `MAP_ALL
            |=> fwd.apply && fwd.ports == `PORTS_ALL;
    endproperty
    a_map_all: assert property (p_map_all)
        else $error("all-port map not decoded");

    // 0000x filters the frame.
    property p_map_filter;
        @(posedge mclk) disable iff (!resetn)
        hit && enable && port_map[4:1] == 4'h0
            |=> fwd.apply && fwd.ports == `PORTS_NONE;
    endproperty
    a_map_filter: assert property (p_map_filter)
        else $error("filter map not decoded");

endmodule : unknown_port_decode

// ==== logic/unknown_dest_fwd_and_queue_map.sv ====
`timescale 1ns/100ps
`include "fwd_cfg.svh"

module unknown_dest_fwd_and_queue_map (
    input wire logic mclk, // Core clock, 100 MHz.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    input wire logic [7:0] reg_addr, // Register offset.
    input wire logic [7:0] reg_wdata, // Write data.
    output logic [7:0] reg_rdata, // Read data, one cycle after reg_rd.
    input wire logic two_queue_mode, // Two-queue configuration selected.
    input fwd_pkg::frame_req_s req, // Frame to classify.
    output fwd_pkg::prio_res_s res, // Priority and queue answer.
    output fwd_pkg::fwd_s ucast_fwd, // Unknown unicast forwarding.
    output fwd_pkg::fwd_s mcast_fwd, // Unknown non-IP multicast forwarding.
    output logic [1:0] drive_strength // Stored drive strength code.
);

    // ======================================================================
    // Configuration storage.
    logic [1:0] tag4_reg;
    logic [1:0] split_reg;
    logic ucast_en_reg;
    logic [4:0] ucast_map_reg;
    logic mcast_en_reg;
    logic [4:0] mcast_map_reg;
    logic [1:0] drive_reg;
    logic [1:0] prio_next;
    logic [1:0] hit;
    logic [1:0] fwd_en;
    logic [4:0] fwd_map [2];
    fwd_pkg::fwd_s fwd_out [2];

    // Writes touch only the writable fields; the rest is never stored.
    // reserved ignore
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tag4_reg <= `TAG4_RESET;
            split_reg <= `SPLIT_RESET;
            ucast_en_reg <= `FWD_EN_RESET;
            ucast_map_reg <= `FWD_MAP_RESET;
            mcast_en_reg <= `FWD_EN_RESET;
            mcast_map_reg <= `FWD_MAP_RESET;
            drive_reg <= `DRIVE_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_TAG_HIGH_MAP: begin
                    tag4_reg <= reg_wdata[`TAG4_MSB:`TAG4_LSB];
                end
                `OFS_QUEUE_SPLIT: begin
                    split_reg <= reg_wdata[`SPLIT_MSB:`SPLIT_LSB];
                end
                `OFS_UNK_UCAST: begin
                    ucast_en_reg <= reg_wdata[`FWD_EN_BIT];
                    ucast_map_reg <= reg_wdata[`FWD_MAP_MSB:`FWD_MAP_LSB];
                end
                `OFS_DRIVE_UNK_MCAST: begin
                    drive_reg <= reg_wdata[`DRIVE_MSB:`DRIVE_LSB];
                    mcast_en_reg <= reg_wdata[`FWD_EN_BIT];
                    mcast_map_reg <= reg_wdata[`FWD_MAP_MSB:`FWD_MAP_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // Read path; unmapped offsets and unheld bits read as zero, except the split register's low bits, which read 04.
    // reserved readback
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_TAG_HIGH_MAP: reg_rdata <= {6'h00, tag4_reg};
                `OFS_QUEUE_SPLIT: reg_rdata <= {split_reg, `SPLIT_RSVD_VALUE};
                `OFS_UNK_UCAST: begin
                    reg_rdata <= {2'h0, ucast_en_reg, ucast_map_reg};
                end
                `OFS_DRIVE_UNK_MCAST: begin
                    reg_rdata <= {drive_reg, mcast_en_reg, mcast_map_reg};
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // The drive code is only recorded; pads are outside this block.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            drive_strength <= `DRIVE_RESET;
        end else begin
            drive_strength <= drive_reg;
        end
    end

    // ======================================================================
    // Priority and queue fold.
    // tag four
    always_comb begin
        prio_next = req.ext_prio;
        if (!req.use_ext && req.pcp == `PCP_FOUR) begin
            prio_next = tag4_reg;
        end
    end

    // Four-queue mode reports high_queue as zero; prio is then the queue.
    // two-queue fold
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            res <= '0;
        end else begin
            res.valid <= req.valid;
            res.prio <= prio_next;
            res.high_queue <= req.valid && two_queue_mode &&
                fwd_pkg::fold_high(split_reg, prio_next);
        end
    end

    // ======================================================================
    // Unknown destination forwarding, one decoder per frame class.
    // unicast enable
    assign hit[0] = req.valid && req.unk_ucast;
    assign fwd_en[0] = ucast_en_reg;
    assign fwd_map[0] = ucast_map_reg;
    assign hit[1] = req.valid && req.unk_mcast && !req.ip_mcast;
    assign fwd_en[1] = mcast_en_reg;
    assign fwd_map[1] = mcast_map_reg;

    for (genvar k = 0; k < 2; k++) begin : g_dec
        unknown_port_decode u_dec (
            .mclk(mclk),
            .resetn(resetn),
            .hit(hit[k]),
            .enable(fwd_en[k]),
            .port_map(fwd_map[k]),
            .fwd(fwd_out[k])
        );
    end

    assign ucast_fwd = fwd_out[0];
    assign mcast_fwd = fwd_out[1];

    // ======================================================================
    // Checks.
    sequence s_tag_four;
        req.valid && !req.use_ext && req.pcp == `PCP_FOUR;
    endsequence

    property p_tag_four;
        @(posedge mclk) disable iff (!resetn)
        s_tag_four |=> res.valid && res.prio == $past(tag4_reg);
    endproperty
    a_tag_four: assert property (p_tag_four)
        else $error("tag four priority not taken from its field");

    property p_four_queue;
        @(posedge mclk) disable iff (!resetn)
        req.valid && !two_queue_mode |=> !res.high_queue;
    endproperty
    a_four_queue: assert property (p_four_queue)
        else $error("high queue flagged outside two-queue mode");

    property p_split_three;
        @(posedge mclk) disable iff (!resetn)
        req.valid && two_queue_mode && split_reg == `SPLIT_AT_THREE
            |=> res.high_queue == (res.prio == 2'h3);
    endproperty
    a_split_three: assert property (p_split_three)
        else $error("split 00 folded wrongly");

    property p_split_two;
        @(posedge mclk) disable iff (!resetn)
        req.valid && two_queue_mode && split_reg == `SPLIT_AT_TWO
            |=> res.high_queue == res.prio[1];
    endproperty
    a_split_two: assert property (p_split_two)
        else $error("split 10 folded wrongly");

    property p_split_one;
        @(posedge mclk) disable iff (!resetn)
        req.valid && two_queue_mode && split_reg == `SPLIT_AT_ONE
            |=> res.high_queue == (res.prio != 2'h0);
    endproperty
    a_split_one: assert property (p_split_one)
        else $error("split 11 folded wrongly");

    property p_ucast_off;
        @(posedge mclk) disable iff (!resetn)
        !ucast_en_reg |=> !ucast_fwd.apply && ucast_fwd.ports == `PORTS_NONE;
    endproperty
    a_ucast_off: assert property (p_ucast_off)
        else $error("unicast map applied while disabled");

    property p_ucast_both;
        @(posedge mclk) disable iff (!resetn)
        hit[0] && ucast_en_reg && ucast_map_reg[4:1] == `MAP_BOTH
            |=> ucast_fwd.ports == `PORTS_BOTH;
    endproperty
    a_ucast_both: assert property (p_ucast_both)
        else $error("unicast map to both ports not decoded");

    property p_mcast_off;
        @(posedge mclk) disable iff (!resetn)
        !mcast_en_reg |=> !mcast_fwd.apply;
    endproperty
    a_mcast_off: assert property (p_mcast_off)
        else $error("multicast map applied while disabled");

    property p_ip_mcast;
        @(posedge mclk) disable iff (!resetn)
        req.valid && req.ip_mcast |=> !mcast_fwd.apply;
    endproperty
    a_ip_mcast: assert property (p_ip_mcast)
        else $error("multicast map applied to IP multicast");

    property p_mcast_port2;
        @(posedge mclk) disable iff (!resetn)
        hit[1] && mcast_en_reg && mcast_map_reg[4:1] == `MAP_PORT2
            |=> mcast_fwd.apply && mcast_fwd.ports == `PORTS_P2;
    endproperty
    a_mcast_port2: assert property (p_mcast_port2)
        else $error("multicast map to port 2 not decoded");

    property p_rsvd_read;
        @(posedge mclk) disable iff (!resetn)
        reg_rd && reg_addr == `OFS_QUEUE_SPLIT
            |=> reg_rdata[5:0] == `SPLIT_RSVD_VALUE;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved split bits read wrong");

endmodule : unknown_dest_fwd_and_queue_map

// ==== verification/unknown_dest_fwd_and_queue_map_test.sv ====
`timescale 1ns/100ps
`include "fwd_cfg.svh"

module unknown_dest_fwd_and_queue_map_test;
    logic mclk;
    logic resetn;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic two_queue_mode;
    fwd_pkg::frame_req_s req;
    fwd_pkg::prio_res_s res;
    fwd_pkg::fwd_s ucast_fwd;
    fwd_pkg::fwd_s mcast_fwd;
    fwd_pkg::fwd_s seen_fwd;
    fwd_pkg::prio_res_s seen_res;
    logic [1:0] drive_strength;
    logic [7:0] rd;
    logic [7:0] ofs;
    int bad_count;
    int n_compared;
    // Every decoded code plus the reserved one; bit 0 is toggled on the reserved code only.
    logic [4:0] maps [6] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h07, 5'h1E};
    logic [1:0] splits [3] = '{2'h0, 2'h2, 2'h3};

    unknown_dest_fwd_and_queue_map u_unknown_dest_fwd_and_queue_map (
        .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .two_queue_mode(two_queue_mode), .req(req), .res(res),
        .ucast_fwd(ucast_fwd), .mcast_fwd(mcast_fwd),
        .drive_strength(drive_strength)
    );

    // ======================================================================
    // Clock and shared tasks.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // An idle edge closes each access, so strobes never toggle twice at once.
    task automatic reg_write(logic [7:0] addr, logic [7:0] data);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
        @(posedge mclk) #1;
    endtask : reg_write

    task automatic reg_read(logic [7:0] addr, output logic [7:0] data);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        data = reg_rdata;
        @(posedge mclk) #1;
    endtask : reg_read

    // Answers are registered, so they are sampled just after the next edge.
    // They stand for one cycle only, so they are kept before the idle edge.
    task automatic classify(logic [2:0] pcp, logic ext, logic [1:0] prio,
                            logic uu, logic um, logic ipm);
        req = '{1'b1, pcp, ext, prio, uu, um, ipm};
        @(posedge mclk) #1;
        seen_fwd = um ? mcast_fwd : ucast_fwd;
        seen_res = res;
        req = '0;
        @(posedge mclk) #1;
    endtask : classify

    function automatic logic exp_high(logic [1:0] split, logic [1:0] p);
        if (split == 2'h0) return p == 2'h3;
        if (split == 2'h3) return p != 2'h0;
        return p[1];
    endfunction : exp_high

    function automatic logic [3:0] exp_ports(logic [4:0] map);
        case (map[4:1])
            4'h1: return 4'h1;
            4'h2: return 4'h2;
            4'h3: return 4'h3;
            4'hF: return 4'hF;
            default: return 4'h0;
        endcase
    endfunction : exp_ports

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // A hung run is cut short and counted as a failure.
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    // ======================================================================
    // Main sequence.
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        two_queue_mode = 1'b0;
        req = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (3) @(posedge mclk);
        #1 resetn = 1'b1;
        reg_read(`OFS_TAG_HIGH_MAP, rd);
        check("tag_map_reg", rd, 8'h02);
        reg_read(`OFS_QUEUE_SPLIT, rd);
        check("split_reg", rd, 8'h84);
        reg_read(`OFS_UNK_UCAST, rd);
        check("ucast_reg", rd, 8'h00);
        reg_read(`OFS_DRIVE_UNK_MCAST, rd);
        check("mcast_reg", rd, 8'h40);
        reg_read(8'h80, rd);
        check("unmapped_reg", rd, 8'h00);
        check("drive", {6'h00, drive_strength}, 8'h01);
        $display("test reset_values done");
        // writes to read-only bits are dropped.
        reg_write(`OFS_QUEUE_SPLIT, 8'hFF);
        reg_read(`OFS_QUEUE_SPLIT, rd);
        check("split_reg_ro", rd, 8'hC4);
        reg_write(`OFS_UNK_UCAST, 8'hFF);
        reg_read(`OFS_UNK_UCAST, rd);
        check("ucast_reg_ro", rd, 8'h3F);
        reg_write(`OFS_DRIVE_UNK_MCAST, 8'hFF);
        reg_read(`OFS_DRIVE_UNK_MCAST, rd);
        check("mcast_reg_rw", rd, 8'hFF);
        check("drive_rw", {6'h00, drive_strength}, 8'h03);
        $display("test read_only_bits done");
        // tag four uses the programmed field.
        two_queue_mode = 1'b1;
        reg_write(`OFS_QUEUE_SPLIT, 8'h80);
        classify(3'h4, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        check("tag4_prio", {6'h00, seen_res.prio}, 8'h02);
        check("tag4_queue", {7'h00, seen_res.high_queue}, 8'h01);
        reg_write(`OFS_TAG_HIGH_MAP, 8'h01);
        classify(3'h4, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        check("tag4_prio_w", {6'h00, seen_res.prio}, 8'h01);
        check("tag4_valid", {7'h00, seen_res.valid}, 8'h01);
        $display("test tag_four done");
        // every supported split against every result.
        for (int s = 0; s < 3; s++) begin
            reg_write(`OFS_QUEUE_SPLIT, {splits[s], 6'h00});
            for (int p = 0; p < 4; p++) begin
                classify(3'h0, 1'b1, 2'(p), 1'b0, 1'b0, 1'b0);
                check("queue", {7'h00, seen_res.high_queue},
                      {7'h00, exp_high(splits[s], 2'(p))});
            end
        end
        two_queue_mode = 1'b0;
        classify(3'h0, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0);
        check("four_queue", {7'h00, seen_res.high_queue}, 8'h00);
        $display("test queue_split done");
        // enable gating and every decoded port map code.
        for (int k = 0; k < 2; k++) begin
            ofs = k ? `OFS_DRIVE_UNK_MCAST : `OFS_UNK_UCAST;
            reg_write(ofs, 8'h1E);
            classify(3'h0, 1'b0, 2'h0, k == 0, k == 1, 1'b0);
            check("fwd_off", {7'h00, seen_fwd.apply}, 8'h00);
            for (int m = 0; m < 6; m++) begin
                reg_write(ofs, {3'h1, maps[m]});
                classify(3'h0, 1'b0, 2'h0, k == 0, k == 1, 1'b0);
                check("fwd_on", {7'h00, seen_fwd.apply}, 8'h01);
                check("fwd_ports", {4'h0, seen_fwd.ports},
                      {4'h0, exp_ports(maps[m])});
            end
        end
        $display("test port_maps done");
        // IP multicast is left to other controls.
        classify(3'h0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b1);
        check("ip_mcast", {7'h00, seen_fwd.apply}, 8'h00);
        $display("test ip_multicast done");
        tally_and_finish();
    end

endmodule : unknown_dest_fwd_and_queue_map_test
